// [logic/jtc_defs.svh]
// Constants of the test access port controller
`ifndef JTC_DEFS_SVH
`define JTC_DEFS_SVH

`define JTC_IR_W          3
`define JTC_BSR_LEN       174
`define JTC_ID_W          32

`define JTC_IR_CAPTURE    3'h4
`define JTC_OP_EXTEST     3'h0
`define JTC_OP_IDCODE     3'h1
`define JTC_OP_SAMPLE     3'h2
`define JTC_OP_BYPASS     3'h7
`define JTC_IR_RESET      `JTC_OP_IDCODE

`define JTC_TMS_RESET_CNT 3'h5
`define JTC_TMS_CNT_W     3

`endif

// [logic/jtc_pkg.sv]
// Types shared by the test access port controller modules
package jtc_pkg;

   typedef enum logic [3:0] {
      TLR, IDLE,
      SEL_DR, CAP_DR, SH_DR, EX1_DR, PAUSE_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAUSE_IR, EX2_IR, UPD_IR
   } jtc_state_t;

   typedef enum logic [1:0] {
      SEL_BSR, SEL_ID, SEL_BYP
   } jtc_dsel_t;

   typedef struct packed {
      logic tlr;
      logic cap_dr;
      logic sh_dr;
      logic upd_dr;
      logic cap_ir;
      logic sh_ir;
      logic upd_ir;
   } jtc_phase_t;

endpackage

// [logic/jtc_tap_fsm.sv]
// Sixteen-state controller sequencing the scans on the test clock
`timescale 1ns/100ps
module jtc_tap_fsm (
   input  wire logic             tck_i,
   input  wire logic             rst_n_i,
   input  wire logic             tms_i,
   output jtc_pkg::jtc_state_t   state_o,
   output jtc_pkg::jtc_phase_t   phase_o
);

   jtc_pkg::jtc_state_t state_reg;
   jtc_pkg::jtc_state_t state_next;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         jtc_pkg::TLR:      state_next = tms_i ? jtc_pkg::TLR    : jtc_pkg::IDLE;
         jtc_pkg::IDLE:     state_next = tms_i ? jtc_pkg::SEL_DR : jtc_pkg::IDLE;
         jtc_pkg::SEL_DR:   state_next = tms_i ? jtc_pkg::SEL_IR : jtc_pkg::CAP_DR;
         jtc_pkg::CAP_DR:   state_next = tms_i ? jtc_pkg::EX1_DR : jtc_pkg::SH_DR;
         jtc_pkg::SH_DR:    state_next = tms_i ? jtc_pkg::EX1_DR : jtc_pkg::SH_DR;
         jtc_pkg::EX1_DR:   state_next = tms_i ? jtc_pkg::UPD_DR : jtc_pkg::PAUSE_DR;
         jtc_pkg::PAUSE_DR: state_next = tms_i ? jtc_pkg::EX2_DR : jtc_pkg::PAUSE_DR;
         jtc_pkg::EX2_DR:   state_next = tms_i ? jtc_pkg::UPD_DR : jtc_pkg::SH_DR;
         jtc_pkg::UPD_DR:   state_next = tms_i ? jtc_pkg::SEL_DR : jtc_pkg::IDLE;
         jtc_pkg::SEL_IR:   state_next = tms_i ? jtc_pkg::TLR    : jtc_pkg::CAP_IR;
         jtc_pkg::CAP_IR:   state_next = tms_i ? jtc_pkg::EX1_IR : jtc_pkg::SH_IR;
         jtc_pkg::SH_IR:    state_next = tms_i ? jtc_pkg::EX1_IR : jtc_pkg::SH_IR;
         jtc_pkg::EX1_IR:   state_next = tms_i ? jtc_pkg::UPD_IR : jtc_pkg::PAUSE_IR;
         jtc_pkg::PAUSE_IR: state_next = tms_i ? jtc_pkg::EX2_IR : jtc_pkg::PAUSE_IR;
         jtc_pkg::EX2_IR:   state_next = tms_i ? jtc_pkg::UPD_IR : jtc_pkg::SH_IR;
         jtc_pkg::UPD_IR:   state_next = tms_i ? jtc_pkg::SEL_DR : jtc_pkg::IDLE;
         default:           state_next = jtc_pkg::TLR;
      endcase
   end

   // Moves only on test clock edges
   always_ff @(posedge tck_i) begin
      if (!rst_n_i) begin
         state_reg <= jtc_pkg::TLR;
      end else begin
         state_reg <= state_next;
      end
   end

   assign state_o        = state_reg;
   assign phase_o.tlr    = (state_reg == jtc_pkg::TLR);
   assign phase_o.cap_dr = (state_reg == jtc_pkg::CAP_DR);
   assign phase_o.sh_dr  = (state_reg == jtc_pkg::SH_DR);
   assign phase_o.upd_dr = (state_reg == jtc_pkg::UPD_DR);
   assign phase_o.cap_ir = (state_reg == jtc_pkg::CAP_IR);
   assign phase_o.sh_ir  = (state_reg == jtc_pkg::SH_IR);
   assign phase_o.upd_ir = (state_reg == jtc_pkg::UPD_IR);

   a_sel_dr_branch: assert property (@(posedge tck_i) disable iff (!rst_n_i)
      state_reg == jtc_pkg::SEL_DR |=> state_reg == (($past(tms_i)) ? jtc_pkg::SEL_IR : jtc_pkg::CAP_DR))
      else $error("select-DR went the wrong way");

   a_sel_ir_branch: assert property (@(posedge tck_i) disable iff (!rst_n_i)
      state_reg == jtc_pkg::SEL_IR |=> state_reg == (($past(tms_i)) ? jtc_pkg::TLR : jtc_pkg::CAP_IR))
      else $error("select-IR went the wrong way");

endmodule

// [logic/jtc_tap_top.sv]
// Test access port: scan registers, serial output and crossing to the system clock
`timescale 1ns/100ps
`include "jtc_defs.svh"
module jtc_tap_top #(
   parameter logic [`JTC_ID_W-1:0] ID_CODE = 32'h0000_0001 // Arbitrary value
) (
   input  wire logic                    ref_clk_i,
   input  wire logic                    nrst_i,
   input  wire logic                    tck_i,
   input  wire logic                    tms_i,
   input  wire logic                    tdi_i,
   output wire logic                    tdo_o,
   output wire logic                    tdo_oe_o,
   input  wire logic [`JTC_BSR_LEN-1:0] pin_in_i,
   input  wire logic [`JTC_BSR_LEN-1:0] core_out_i,
   output wire logic [`JTC_BSR_LEN-1:0] pin_o,
   output wire logic                    test_mode_o
);

   function automatic jtc_pkg::jtc_dsel_t jtc_sel(input logic [`JTC_IR_W-1:0] ir);
      if (ir == `JTC_OP_EXTEST || ir == `JTC_OP_SAMPLE) begin
         jtc_sel = jtc_pkg::SEL_BSR;
      end else if (ir == `JTC_OP_IDCODE) begin
         jtc_sel = jtc_pkg::SEL_ID;
      end else begin
         jtc_sel = jtc_pkg::SEL_BYP;
      end
   endfunction

   // Test clock domain
   logic                    rst_s1_reg;
   logic                    rst_s2_reg;
   logic                    rst_n_tck;
   logic [`JTC_BSR_LEN-1:0] pin_s1_reg;
   logic [`JTC_BSR_LEN-1:0] pin_s2_reg;

   // Reset and pads come from outside the test clock, two stages each
   always_ff @(posedge tck_i) begin
      rst_s1_reg <= nrst_i;
      rst_s2_reg <= rst_s1_reg;
      pin_s1_reg <= pin_in_i;
      pin_s2_reg <= pin_s1_reg;
   end

   assign rst_n_tck = rst_s2_reg;

   jtc_pkg::jtc_state_t state;
   jtc_pkg::jtc_phase_t phase;

   jtc_tap_fsm u_fsm (
      .tck_i   (tck_i),
      .rst_n_i (rst_n_tck),
      .tms_i   (tms_i),
      .state_o (state),
      .phase_o (phase)
   );

   logic [`JTC_IR_W-1:0]    ir_reg;
   logic [`JTC_IR_W-1:0]    ir_next;
   logic [`JTC_IR_W-1:0]    ir_shift_reg;
   logic [`JTC_IR_W-1:0]    ir_shift_next;
   logic [`JTC_BSR_LEN-1:0] bsr_shift_reg;
   logic [`JTC_BSR_LEN-1:0] bsr_shift_next;
   logic [`JTC_BSR_LEN-1:0] bsr_par_reg;
   logic [`JTC_ID_W-1:0]    id_shift_reg;
   logic [`JTC_ID_W-1:0]    id_shift_next;
   logic                    byp_reg;
   logic                    byp_next;
   logic                    tdo_reg;
   logic                    tdo_oe_reg;
   logic                    ext_tck_reg;
   logic                    upd_tgl_reg;

   jtc_pkg::jtc_dsel_t      dsel;
   wire logic               sel_bsr = (dsel == jtc_pkg::SEL_BSR);
   wire logic               sel_id  = (dsel == jtc_pkg::SEL_ID);
   wire logic               sel_byp = (dsel == jtc_pkg::SEL_BYP);
   wire logic               shifting = phase.sh_dr | phase.sh_ir;
   wire logic               dr_out;
   wire logic               tdo_next;

   assign dsel = jtc_sel(ir_reg);

   // Shift stages change only in capture or shift; pause, exit, update hold them
   assign ir_shift_next = phase.cap_ir ? `JTC_IR_CAPTURE :
                          phase.sh_ir  ? {tdi_i, ir_shift_reg[`JTC_IR_W-1:1]} :
                          ir_shift_reg;

   assign bsr_shift_next = (phase.cap_dr && sel_bsr) ? pin_s2_reg :
                           (phase.sh_dr && sel_bsr)  ?
                           {tdi_i, bsr_shift_reg[`JTC_BSR_LEN-1:1]} :
                           bsr_shift_reg;

   assign id_shift_next = (phase.cap_dr && sel_id) ? ID_CODE :
                          (phase.sh_dr && sel_id)  ? {tdi_i, id_shift_reg[`JTC_ID_W-1:1]} :
                          id_shift_reg;

   // Bypass has no parallel input beyond its defined zero
   assign byp_next = (phase.cap_dr && sel_byp) ? 1'b0 :
                     (phase.sh_dr && sel_byp)  ? tdi_i :
                     byp_reg;

   always_ff @(posedge tck_i) begin
      if (!rst_n_tck) begin
         ir_shift_reg  <= `JTC_IR_CAPTURE;
         bsr_shift_reg <= '0;
         id_shift_reg  <= '0;
         byp_reg       <= 1'b0;
      end else begin
         ir_shift_reg  <= ir_shift_next;
         bsr_shift_reg <= bsr_shift_next;
         id_shift_reg  <= id_shift_next;
         byp_reg       <= byp_next;
      end
   end

   // Current instruction moves only in update-IR or the reset state
   assign ir_next = phase.tlr    ? `JTC_IR_RESET :
                    phase.upd_ir ? ir_shift_reg :
                    ir_reg;

   assign dr_out = sel_bsr ? bsr_shift_reg[0] :
                   sel_id  ? id_shift_reg[0]  :
                   byp_reg;

   assign tdo_next = phase.sh_ir ? ir_shift_reg[0] : dr_out;

   // Falling edge: parallel latches and serial output settle mid-cycle for the tester
   always_ff @(negedge tck_i) begin
      if (!rst_n_tck) begin
         ir_reg      <= `JTC_IR_RESET;
         bsr_par_reg <= '0;
         tdo_reg     <= 1'b1;
         tdo_oe_reg  <= 1'b0;
         ext_tck_reg <= 1'b0;
         upd_tgl_reg <= 1'b0;
      end else begin
         ir_reg      <= ir_next;
         tdo_reg     <= shifting ? tdo_next : 1'b1;
         tdo_oe_reg  <= shifting;
         ext_tck_reg <= (ir_next == `JTC_OP_EXTEST);
         if (phase.upd_dr && sel_bsr) begin
            bsr_par_reg <= bsr_shift_reg;
            upd_tgl_reg <= ~upd_tgl_reg;
         end
      end
   end

   assign tdo_o    = tdo_reg;
   assign tdo_oe_o = tdo_oe_reg;

   // System clock domain
   logic                    ext_s1_reg;
   logic                    ext_s2_reg;
   logic                    tgl_s1_reg;
   logic                    tgl_s2_reg;
   logic                    tgl_s3_reg;
   logic [`JTC_BSR_LEN-1:0] par_sys_reg;
   logic [`JTC_BSR_LEN-1:0] pin_reg;
   logic                    test_mode_reg;
   wire logic               upd_seen = tgl_s2_reg ^ tgl_s3_reg;

   // Parallel word is taken only after its toggle has crossed; the tester must
   // leave a few system clocks between two updates, which any real scan does
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         ext_s1_reg    <= 1'b0;
         ext_s2_reg    <= 1'b0;
         tgl_s1_reg    <= 1'b0;
         tgl_s2_reg    <= 1'b0;
         tgl_s3_reg    <= 1'b0;
         par_sys_reg   <= '0;
         pin_reg       <= '0;
         test_mode_reg <= 1'b0;
      end else begin
         ext_s1_reg    <= ext_tck_reg;
         ext_s2_reg    <= ext_s1_reg;
         tgl_s1_reg    <= upd_tgl_reg;
         tgl_s2_reg    <= tgl_s1_reg;
         tgl_s3_reg    <= tgl_s2_reg;
         if (upd_seen) begin
            par_sys_reg <= bsr_par_reg;
         end
         pin_reg       <= ext_s2_reg ? par_sys_reg : core_out_i;
         test_mode_reg <= ext_s2_reg;
      end
   end

   assign pin_o       = pin_reg;
   assign test_mode_o = test_mode_reg;

   // Checks
   logic [`JTC_TMS_CNT_W-1:0] tms_cnt_reg;

   always_ff @(posedge tck_i) begin
      if (!rst_n_tck) begin
         tms_cnt_reg <= '0;
      end else if (!tms_i) begin
         tms_cnt_reg <= '0;
      end else if (tms_cnt_reg != `JTC_TMS_RESET_CNT) begin
         tms_cnt_reg <= tms_cnt_reg + 3'h1;
      end
   end

   a_tms_five_reset: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      tms_cnt_reg == `JTC_TMS_RESET_CNT |-> state == jtc_pkg::TLR)
      else $error("five TMS highs did not reach reset state");

   a_idle_stays: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::IDLE && !tms_i |=> state == jtc_pkg::IDLE && $stable(ir_reg)
      && $stable(bsr_shift_reg))
      else $error("idle did not hold");

   a_capture_ir_pat: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::CAP_IR |=> ir_shift_reg == `JTC_IR_CAPTURE && $stable(ir_reg))
      else $error("capture-IR pattern wrong");

   a_ir_only_update: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      $changed(ir_reg) |-> state == jtc_pkg::UPD_IR || state == jtc_pkg::TLR)
      else $error("instruction changed outside update-IR");

   a_bsr_par_update: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      $changed(bsr_par_reg) |-> state == jtc_pkg::UPD_DR && bsr_par_reg == bsr_shift_reg)
      else $error("boundary parallel output changed outside update-DR");

   a_bsr_shift_step: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::SH_DR && sel_bsr |=>
      bsr_shift_reg == {$past(tdi_i), $past(bsr_shift_reg[`JTC_BSR_LEN-1:1])})
      else $error("boundary register did not shift one stage");

   a_bsr_capture: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::CAP_DR && sel_bsr |=> bsr_shift_reg == $past(pin_s2_reg))
      else $error("boundary register did not capture pins");

   a_pause_dr_hold: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::PAUSE_DR |=> $stable(bsr_shift_reg) && $stable(id_shift_reg)
      && $stable(byp_reg))
      else $error("data register moved in pause-DR");

   // Two one-way checks, so unknowns ahead of the first reset stay vacuous
   a_tdo_drive_win: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      tdo_oe_reg |-> state == jtc_pkg::SH_DR || state == jtc_pkg::SH_IR)
      else $error("TDO enable outside shift states");

   a_tdo_oe_shift: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::SH_DR || state == jtc_pkg::SH_IR |-> tdo_oe_reg)
      else $error("TDO not driven in a shift state");

   a_exit1_dr_path: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::EX1_DR ##1 state == jtc_pkg::PAUSE_DR |-> !$past(tms_i)
      && $stable(bsr_shift_reg))
      else $error("exit1-DR branch wrong");

   a_extest_drive: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      test_mode_reg |-> pin_reg == $past(par_sys_reg))
      else $error("pins not driven from boundary latch in test mode");

   a_pin_core_path: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      !test_mode_reg |-> pin_reg == $past(core_out_i))
      else $error("pins not following the core outside test mode");

   a_tlr_ir_reset: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::TLR |-> ir_reg == `JTC_IR_RESET && !ext_tck_reg)
      else $error("reset state did not select the identification instruction");

   a_tlr_stays: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::TLR && tms_i |=> state == jtc_pkg::TLR)
      else $error("reset state left with TMS high");

   a_idle_branch: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::IDLE && tms_i |=> state == jtc_pkg::SEL_DR)
      else $error("idle did not move to select-DR");

   a_cap_dr_branch: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::CAP_DR |=> state == ($past(tms_i) ? jtc_pkg::EX1_DR : jtc_pkg::SH_DR))
      else $error("capture-DR went the wrong way");

   a_sh_dr_branch: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::SH_DR |=> state == ($past(tms_i) ? jtc_pkg::EX1_DR : jtc_pkg::SH_DR))
      else $error("shift-DR went the wrong way");

   a_pause_dr_branch: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::PAUSE_DR |=> state == ($past(tms_i) ? jtc_pkg::EX2_DR : jtc_pkg::PAUSE_DR))
      else $error("pause-DR went the wrong way");

   a_exit2_dr_path: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::EX2_DR |=> state == ($past(tms_i) ? jtc_pkg::UPD_DR : jtc_pkg::SH_DR)
      && $stable(ir_reg))
      else $error("exit2-DR branch wrong");

   a_upd_dr_hold: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::UPD_DR |=> $stable(bsr_shift_reg) && $stable(id_shift_reg)
      && $stable(byp_reg) && $stable(ir_reg))
      else $error("register moved in update-DR");

   a_cap_ir_branch: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::CAP_IR |=> state == ($past(tms_i) ? jtc_pkg::EX1_IR : jtc_pkg::SH_IR))
      else $error("capture-IR went the wrong way");

   a_sh_ir_branch: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::SH_IR |=> state == ($past(tms_i) ? jtc_pkg::EX1_IR : jtc_pkg::SH_IR))
      else $error("shift-IR went the wrong way");

   a_ir_shift_step: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::SH_IR |=>
      ir_shift_reg == {$past(tdi_i), $past(ir_shift_reg[`JTC_IR_W-1:1])})
      else $error("instruction register did not shift one stage");

   a_exit1_ir_keep: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::EX1_IR |=> state == ($past(tms_i) ? jtc_pkg::UPD_IR : jtc_pkg::PAUSE_IR)
      && $stable(bsr_shift_reg) && $stable(id_shift_reg) && $stable(byp_reg))
      else $error("exit1-IR branch wrong");

   a_pause_ir_hold: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::PAUSE_IR |=> $stable(ir_shift_reg)
      && state == ($past(tms_i) ? jtc_pkg::EX2_IR : jtc_pkg::PAUSE_IR))
      else $error("instruction register moved in pause-IR");

   a_exit2_ir_path: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::EX2_IR |=> state == ($past(tms_i) ? jtc_pkg::UPD_IR : jtc_pkg::SH_IR))
      else $error("exit2-IR branch wrong");

   a_upd_ir_latch: assert property (@(posedge tck_i) disable iff (!rst_n_tck)
      state == jtc_pkg::UPD_IR |-> ir_reg == ir_shift_reg)
      else $error("instruction not latched in update-IR");

endmodule

// [bench/jtc_jtag_master.sv]
// Behavioural board-level scan master driving the test port
`timescale 1ns/100ps
module jtc_jtag_master (
   output logic         tck_o,
   output logic         tms_o,
   output logic         tdi_o,
   input  wire logic    tdo_i,
   output logic [173:0] cap_o,
   output logic         done_o
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
      cap_o = '0;
      done_o = 1'b0;
   end

   // Test clock runs only inside these cycles, still between frames
   task automatic clk1(input logic tms, input logic tdi, output logic tdo);
      tms_o = tms;
      tdi_o = tdi;
      #16;
      tck_o = 1'b1;
      tdo = tdo_i;
      #16;
      tck_o = 1'b0;
   endtask

   task automatic reset5();
      logic d;
      repeat (5) clk1(1'b1, 1'b0, d);
      clk1(1'b0, 1'b0, d);
   endtask

   // Scan from idle back to idle, optional pause after bit pause_at-1
   task automatic scan(input logic ir, input int len, input logic [173:0] din, input int pause_at);
      logic         d;
      logic [173:0] q;
      q = '0;
      // One cycle resting in idle before the scan
      clk1(1'b0, 1'b0, d);
      clk1(1'b1, 1'b0, d);
      if (ir) clk1(1'b1, 1'b0, d);
      clk1(1'b0, 1'b0, d);
      clk1(1'b0, 1'b0, d);
      for (int i = 0; i < len; i++) begin
         clk1(i == len - 1 || i == pause_at - 1, din[i], d);
         q[i] = d;
         if (i == pause_at - 1 && i != len - 1) begin
            clk1(1'b0, ~din[i], d);
            clk1(1'b0, din[i], d);
            clk1(1'b1, ~din[i], d);
            clk1(1'b0, din[i], d);
         end
      end
      clk1(1'b1, din[len-1], d);
      // Released data line shows the inverse, never a stale bit
      clk1(1'b0, ~din[len-1], d);
      cap_o = q;
      done_o = ~done_o;
   endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench of the test access port controller
`timescale 1ns/100ps
module testbench;
   localparam logic [31:0] ID_VAL = 32'h0a5c_3e01; // Arbitrary value
   logic         ref_clk;
   logic         nrst;
   wire          tck;
   wire          tms;
   wire          tdi;
   wire          tdo;
   wire          tdo_oe;
   wire          tdo_line;
   wire          done;
   wire  [173:0] cap;
   wire  [173:0] pin_o;
   wire          test_mode;
   logic [173:0] pin_in;
   logic [173:0] core_out;
   logic [173:0] dr;
   logic [173:0] exp_q[$];
   logic [31:0]  seed;
   int           fails;
   int           comparisons;
   int           cycles;

   // Undriven test output is pulled high on the board
   assign tdo_line = tdo_oe ? tdo : 1'b1;

   jtc_tap_top #(.ID_CODE(ID_VAL)) i_jtc_tap_top (
      .ref_clk_i   (ref_clk),
      .nrst_i      (nrst),
      .tck_i       (tck),
      .tms_i       (tms),
      .tdi_i       (tdi),
      .tdo_o       (tdo),
      .tdo_oe_o    (tdo_oe),
      .pin_in_i    (pin_in),
      .core_out_i  (core_out),
      .pin_o       (pin_o),
      .test_mode_o (test_mode)
   );

   jtc_jtag_master i_jtc_jtag_master (
      .tck_o  (tck),
      .tms_o  (tms),
      .tdi_o  (tdi),
      .tdo_i  (tdo_line),
      .cap_o  (cap),
      .done_o (done)
   );

   function automatic logic [173:0] rnd();
      logic [173:0] v;
      v = '0;
      for (int i = 0; i < 6; i++) begin
         seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
         v = {v[141:0], seed};
      end
      return v;
   endfunction

   task automatic check(input string name, input logic [173:0] seen, input logic [173:0] expv);
      comparisons++;
      if (seen !== expv) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, expv, seen);
      end
   endtask

   task automatic results();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic ref_wait(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         results();
      end
   end

   // Oldest noted word is compared whenever a scan result appears
   always @(done) begin
      if (exp_q.size() > 0) begin
         check("scanned word", cap, exp_q.pop_front());
      end
   end

   initial begin
      nrst = 1'b0;
      seed = 32'd88405;
      pin_in = '0;
      core_out = '0;
      fork
         repeat (6) @(posedge ref_clk);
         i_jtc_jtag_master.reset5();
      join
      @(negedge ref_clk);
      nrst = 1'b1;
      pin_in = rnd();
      core_out = rnd();
      i_jtc_jtag_master.reset5();
      exp_q.push_back({142'h0, ID_VAL});
      i_jtc_jtag_master.scan(1'b0, 32, '0, 0);
      exp_q.push_back(174'h4);
      i_jtc_jtag_master.scan(1'b1, 3, 174'h2, 0);
      exp_q.push_back(pin_in);
      dr = rnd();
      i_jtc_jtag_master.scan(1'b0, 174, dr, 0);
      ref_wait(10);
      check("pin_o", pin_o, core_out);
      check("test_mode_o", 174'(test_mode), 174'h0);
      // Instruction scan with a pause in mid-shift
      exp_q.push_back(174'h4);
      i_jtc_jtag_master.scan(1'b1, 3, 174'h0, 1);
      ref_wait(10);
      check("test_mode_o", 174'(test_mode), 174'h1);
      // Word preloaded under sample now reaches the pins
      check("pin_o", pin_o, dr);
      exp_q.push_back(pin_in);
      dr = rnd();
      i_jtc_jtag_master.scan(1'b0, 174, dr, 87);
      ref_wait(10);
      check("pin_o", pin_o, dr);
      // Bypass returns a captured zero then the input delayed one stage
      exp_q.push_back(174'h4);
      i_jtc_jtag_master.scan(1'b1, 3, 174'h7, 0);
      dr = rnd();
      exp_q.push_back({166'h0, dr[6:0], 1'b0});
      i_jtc_jtag_master.scan(1'b0, 8, dr, 0);
      ref_wait(10);
      check("test_mode_o", 174'(test_mode), 174'h0);
      exp_q.push_back(174'h4);
      i_jtc_jtag_master.scan(1'b1, 3, 174'h0, 0);
      i_jtc_jtag_master.reset5();
      ref_wait(10);
      check("test_mode_o", 174'(test_mode), 174'h0);
      check("pin_o", pin_o, core_out);
      exp_q.push_back({142'h0, ID_VAL});
      i_jtc_jtag_master.scan(1'b0, 32, '0, 0);
      ref_wait(4);
      results();
   end
endmodule
